// file: hdl/iox_regs.vh
// Constants for the I/O expander port and change-alert block
`ifndef IOX_REGS_VH
`define IOX_REGS_VH

`define IOX_PTR_INPUT      8'h00
`define IOX_PTR_OUTPUT     8'h01
`define IOX_PTR_POLARITY   8'h02
`define IOX_PTR_CONFIG     8'h03

`define IOX_RST_OUTPUT     8'hFF
`define IOX_RST_POLARITY   8'h00
`define IOX_RST_CONFIG     8'hFF
`define IOX_RST_PTR        8'h00

`define IOX_CLK_PERIOD_NS  10
`define IOX_ALERT_VALID_NS 4000
`define IOX_ALERT_CLEAR_NS 4000
`define IOX_ALERT_VALID_CYC (`IOX_ALERT_VALID_NS / `IOX_CLK_PERIOD_NS)
`define IOX_ALERT_CLEAR_CYC (`IOX_ALERT_CLEAR_NS / `IOX_CLK_PERIOD_NS)

`endif

// file: hdl/iox_sync.v
// Two-flop synchroniser for a vector of asynchronous inputs
`timescale 1ns/1ps
module iox_sync #(
	parameter WIDTH = 8
) (
	clk,
	sys_rst,
	ce,
	async_in,
	sync_out
);
	input              clk;
	input              sys_rst;
	input              ce;
	input  [WIDTH-1:0] async_in;
	output [WIDTH-1:0] sync_out;

	reg    [WIDTH-1:0] meta_r;
	reg    [WIDTH-1:0] sync_r;

	assign sync_out = sync_r;

	always @(posedge clk)
	begin
		if (sys_rst)
		begin
			meta_r <= {WIDTH{1'b0}};
			sync_r <= {WIDTH{1'b0}};
		end
		else if (ce)
		begin
			meta_r <= async_in;
			sync_r <= meta_r;
		end
	end
endmodule

// file: hdl/iox_port.v
// Port pins, direction control and open-drain change alert of an 8-bit I/O expander
//
// Operation
// - Held in reset until supply threshold; then all registers and bus logic default.
// - After reset all eight pins are inputs with drivers off.
// - Output pins driven from output register bit; input pins leave drivers off.
// - Any edge on an input pin raises the alert within 4 us.
// - Alert withdrawn when pin returns to original value or port is read.
// - Read clears alert at ACK/NACK after rising SCL, within 4 us.
// - Pin change during read ACK/NACK pulse may be lost or short.
// - After a clear, every later input change raises the alert again.
// - Transfers to other devices neither set nor clear the alert, except erratum.
// - Transitions on output pins never raise the alert.
// - Switching output to input may raise a false alert on mismatch.
// - Each port read on its own; a read never clears another port's alert.
// - Alert output open drain, active low, pulled high externally.
// - Pointer 00h and another slave acking a read address wrongly clears alert.
// - Alert asserted while any input pin differs from its snapshot taken at the last read clear.
// - Input register tracks pin levels whatever the configured direction.
// - Register pointer persists until a new command byte is written.
`timescale 1ns/1ps
`include "iox_regs.vh"
module iox_port #(
	parameter WIDTH = 8
) (
	clk,
	sys_rst,
	ce,
	por_rise_threshold,
	scl,
	port_pins_in,
	port_pins_out,
	port_pins_oe,
	high_side_driver,
	low_side_driver,
	wr_strobe,
	wr_ptr_strobe,
	wr_data,
	read_ack_self,
	read_ack_other,
	rd_data,
	reg_ptr,
	alert_n_out,
	alert_n_oe
);
	input              clk;
	input              sys_rst;
	input              ce;
	input              por_rise_threshold;
	input              scl;
	input  [WIDTH-1:0] port_pins_in;
	output [WIDTH-1:0] port_pins_out;
	output [WIDTH-1:0] port_pins_oe;
	output [WIDTH-1:0] high_side_driver;
	output [WIDTH-1:0] low_side_driver;
	input              wr_strobe;
	input              wr_ptr_strobe;
	input  [7:0]       wr_data;
	input              read_ack_self;
	input              read_ack_other;
	output [7:0]       rd_data;
	output [7:0]       reg_ptr;
	output             alert_n_out;
	output             alert_n_oe;

	localparam ST_RESET = 2'd0;
	localparam ST_IDLE  = 2'd1;
	localparam ST_CLR   = 2'd2;

	wire   [WIDTH-1:0] pins_s;
	wire   [1:0]       ctl_s;
	wire               scl_s;
	wire               supply_ok;
	wire               hold_rst;
	reg    [1:0]       state_r;
	reg    [1:0]       state_nxt;
	reg    [WIDTH-1:0] out_r;
	reg    [WIDTH-1:0] pol_r;
	reg    [WIDTH-1:0] cfg_r;
	reg    [7:0]       ptr_r;
	reg    [WIDTH-1:0] snap_r;
	reg    [WIDTH-1:0] in_r;
	reg                scl_d_r;
	reg                clr_pend_r;
	reg                alert_oe_r;
	reg                alert_lvl_r;
	reg    [7:0]       rd_r;
	reg    [7:0]       rd_nxt;
	wire   [WIDTH-1:0] mism;
	wire               scl_rise;
	wire               read_clr;
	wire               clr_now;
	wire   [WIDTH-1:0] pin_out_w;
	wire   [WIDTH-1:0] pin_oe_w;
	wire   [WIDTH-1:0] hi_w;
	wire   [WIDTH-1:0] lo_w;

	// Pins, SCL and supply-good flag cross in through two flops
	iox_sync #(.WIDTH(WIDTH)) u_sync_pins (
		.clk      (clk),
		.sys_rst  (sys_rst),
		.ce       (ce),
		.async_in (port_pins_in),
		.sync_out (pins_s)
	);

	iox_sync #(.WIDTH(2)) u_sync_ctl (
		.clk      (clk),
		.sys_rst  (sys_rst),
		.ce       (ce),
		.async_in ({scl, por_rise_threshold}),
		.sync_out (ctl_s)
	);

	assign scl_s     = ctl_s[1];
	assign supply_ok = ctl_s[0];

	// Everything but the state register and the two synchronisers is held at defaults while supply is low
	assign hold_rst  = sys_rst | (ce & (state_r == ST_RESET));

	assign scl_rise  = scl_s & ~scl_d_r;
	assign clr_now   = (state_r == ST_CLR);

	// Mismatch against the snapshot taken at the last read, input pins only
	assign mism      = (pins_s ^ snap_r) & cfg_r;

	// A foreign read clears only while the pointer sits on the input register
	assign read_clr  = read_ack_self |
		(read_ack_other & (ptr_r == `IOX_PTR_INPUT));

	always @*
	begin
		state_nxt = state_r;
		case (state_r)
			ST_RESET:
			begin
				if (supply_ok)
					state_nxt = ST_IDLE;
			end
			ST_IDLE:
			begin
				if (clr_pend_r & scl_rise)
					state_nxt = ST_CLR;
			end
			ST_CLR:
				state_nxt = ST_IDLE;
			default:
				state_nxt = ST_RESET;
		endcase
		if (!supply_ok)
			state_nxt = ST_RESET;
	end

	always @(posedge clk)
	begin
		if (sys_rst)
			state_r <= ST_RESET;
		else if (ce)
			state_r <= state_nxt;
	end

	// Configuration registers and the pointer
	always @(posedge clk)
	begin
		if (hold_rst)
		begin
			out_r <= `IOX_RST_OUTPUT;
			pol_r <= `IOX_RST_POLARITY;
			cfg_r <= `IOX_RST_CONFIG;
			ptr_r <= `IOX_RST_PTR;
		end
		else if (ce)
		begin
			if (wr_ptr_strobe)
				ptr_r <= wr_data;
			else if (wr_strobe)
			begin
				case (ptr_r)
					`IOX_PTR_OUTPUT:   out_r <= wr_data[WIDTH-1:0];
					`IOX_PTR_POLARITY: pol_r <= wr_data[WIDTH-1:0];
					`IOX_PTR_CONFIG:   cfg_r <= wr_data[WIDTH-1:0];
					default:           out_r <= out_r;
				endcase
			end
		end
	end

	// Input register, SCL edge memory and the read-clear machinery
	always @(posedge clk)
	begin
		if (hold_rst)
		begin
			in_r       <= {WIDTH{1'b0}};
			snap_r     <= {WIDTH{1'b0}};
			// Idle level of SCL is high, so no false rise follows reset
			scl_d_r    <= 1'b1;
			clr_pend_r <= 1'b0;
		end
		else if (ce)
		begin
			in_r    <= pins_s;
			scl_d_r <= scl_s;
			// Clear is armed at the ACK/NACK and lands on the following SCL rise
			if (read_clr)
				clr_pend_r <= 1'b1;
			else if (clr_now)
				clr_pend_r <= 1'b0;
			// Snapshot of pins taken at the clear; later edges mismatch again
			if (clr_now)
				snap_r <= pins_s;
		end
	end

	always @*
	begin
		case (ptr_r)
			`IOX_PTR_INPUT:    rd_nxt = in_r ^ pol_r;
			`IOX_PTR_OUTPUT:   rd_nxt = out_r;
			`IOX_PTR_POLARITY: rd_nxt = pol_r;
			`IOX_PTR_CONFIG:   rd_nxt = cfg_r;
			default:           rd_nxt = 8'h00;
		endcase
	end

	always @(posedge clk)
	begin
		if (hold_rst)
			rd_r <= 8'h00;
		else if (ce)
			rd_r <= rd_nxt;
	end

	// Alert pulls low through its enable; the level flop never leaves zero
	always @(posedge clk)
	begin
		if (hold_rst)
		begin
			alert_oe_r  <= 1'b0;
			alert_lvl_r <= 1'b0;
		end
		else if (ce)
		begin
			alert_oe_r  <= (|mism) & ~clr_now;
			alert_lvl_r <= 1'b0;
		end
	end

	// One output stage per pin: both drivers off unless configured as output
	genvar gi;
	generate
		for (gi = 0; gi < WIDTH; gi = gi + 1)
		begin : g_pin
			reg  drv_out_r;
			reg  drv_oe_r;
			reg  drv_hi_r;
			reg  drv_lo_r;
			wire as_out;

			assign as_out = ~cfg_r[gi];

			always @(posedge clk)
			begin
				if (hold_rst)
				begin
					drv_out_r <= 1'b0;
					drv_oe_r  <= 1'b0;
					drv_hi_r  <= 1'b0;
					drv_lo_r  <= 1'b0;
				end
				else if (ce)
				begin
					drv_out_r <= out_r[gi] & as_out;
					drv_oe_r  <= as_out;
					drv_hi_r  <= out_r[gi] & as_out;
					drv_lo_r  <= ~out_r[gi] & as_out;
				end
			end

			assign pin_out_w[gi] = drv_out_r;
			assign pin_oe_w[gi]  = drv_oe_r;
			assign hi_w[gi]      = drv_hi_r;
			assign lo_w[gi]      = drv_lo_r;
		end
	endgenerate

	assign port_pins_out    = pin_out_w;
	assign port_pins_oe     = pin_oe_w;
	assign high_side_driver = hi_w;
	assign low_side_driver  = lo_w;
	assign rd_data          = rd_r;
	assign reg_ptr          = ptr_r;
	assign alert_n_out      = alert_lvl_r;
	assign alert_n_oe       = alert_oe_r;
endmodule

// file: verification/iox_props.sv
// Checker for port drivers, pointer and change alert
`timescale 1ns/1ps
module iox_props (
	input wire       clk,
	input wire       sys_rst,
	input wire       ce,
	input wire       por_rise_threshold,
	input wire [7:0] port_pins_in,
	input wire [7:0] port_pins_out,
	input wire [7:0] port_pins_oe,
	input wire [7:0] high_side_driver,
	input wire [7:0] low_side_driver,
	input wire       wr_ptr_strobe,
	input wire [7:0] wr_data,
	input wire       read_ack_other,
	input wire [7:0] reg_ptr,
	input wire       alert_n_out,
	input wire       alert_n_oe
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	chk_drv_high: assert property (high_side_driver == (port_pins_oe & port_pins_out))
		else $error("high side driver mismatch");
	chk_drv_low: assert property (low_side_driver == (port_pins_oe & ~port_pins_out))
		else $error("low side driver mismatch");
	chk_alert_od: assert property (alert_n_out == 1'b0)
		else $error("alert pin drives high");
	chk_rst_off: assert property (disable iff (1'b0) sys_rst |=> !port_pins_oe && !alert_n_oe)
		else $error("drivers on after reset");
	chk_por_off: assert property ((!por_rise_threshold && ce) [*6] |-> !port_pins_oe && !alert_n_oe)
		else $error("drivers on while supply low");
	chk_alert_set: assert property (!alert_n_oe && ce && $stable(port_pins_oe)
		&& ((port_pins_in ^ $past(port_pins_in)) & ~port_pins_oe) != 8'h00
		|-> ##[1:5] alert_n_oe)
		else $error("input change raised no alert");
	chk_ptr_load: assert property (wr_ptr_strobe && ce && por_rise_threshold
		|=> reg_ptr == $past(wr_data))
		else $error("pointer not loaded");
	chk_other_keep: assert property (alert_n_oe && read_ack_other && reg_ptr != 8'h00
		|=> alert_n_oe [*8])
		else $error("foreign read cleared alert");
endmodule

// file: verification/iox_master.sv
// Bus-master stand-in: SCL pulses of a read byte and ack flags
`timescale 1ns/1ps
module iox_master (
	input wire   clk,
	output logic scl,
	output logic ack_self,
	output logic ack_other
);
	initial
	begin
		scl = 1;
		{ack_self, ack_other} = 2'b00;
	end
	// Eight data clocks, then the ack flag ahead of the ninth rise
	task automatic read_frame(input logic other);
		repeat (8)
		begin
			#40 scl = 0;
			#40 scl = 1;
		end
		@(posedge clk);
		#1 {ack_self, ack_other} = {!other, other};
		@(posedge clk);
		#1 {ack_self, ack_other} = 2'b00;
		#40 scl = 0;
		#40 scl = 1;
	endtask
endmodule

// file: verification/tb_top.sv
// Self-checking bench for the port and change-alert block
`timescale 1ns/1ps
module tb_top;
	logic        clk, sys_rst, ce, por, wps, ws;
	logic [7:0]  ext, wd;
	logic [31:0] rows [4];
	wire  [7:0]  pins, po, oe, hi, lo, rd, ptr;
	wire         scl, ack_s, ack_o, an, aoe;
	int          failures, samples_checked;
	assign pins = (oe & po) | (~oe & ext);
	iox_port DUT (.clk(clk), .sys_rst(sys_rst), .ce(ce), .por_rise_threshold(por), .scl(scl),
		.port_pins_in(pins), .port_pins_out(po), .port_pins_oe(oe), .high_side_driver(hi),
		.low_side_driver(lo), .wr_strobe(ws), .wr_ptr_strobe(wps), .wr_data(wd),
		.read_ack_self(ack_s), .read_ack_other(ack_o), .rd_data(rd), .reg_ptr(ptr),
		.alert_n_out(an), .alert_n_oe(aoe));
	iox_master m (.clk(clk), .scl(scl), .ack_self(ack_s), .ack_other(ack_o));
	task chk(input string n, input logic [7:0] e, input logic [7:0] g);
		samples_checked++;
		if (g !== e)
		begin
			failures++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask
	task cka(input logic e);
		chk("alert", {7'h00, e}, {7'h00, aoe});
	endtask
	task cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task wr(input logic [7:0] p, input logic [7:0] d);
		{wps, wd} = {1'b1, p};
		cyc(1);
		{wps, ws, wd} = {2'b01, d};
		cyc(1);
		ws = 0;
	endtask
	task end_sim;
		$display("checked %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial
	begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	initial
	begin
		#100000;
		failures++;
		end_sim;
	end
	initial
	begin
		{sys_rst, ce, por, wps, ws, ext, wd} = {3'b111, 2'b00, 16'h0000};
		failures = 0;
		samples_checked = 0;
		rows = '{32'hFF00_0000, 32'h00A5_A55A, 32'h0F3C_30C0, 32'hF0FF_0F00};
		cyc(10);
		sys_rst = 0;
		chk("oe", 8'h00, oe);
		cyc(3);
		foreach (rows[i])
		begin
			wr(8'h03, rows[i][31:24]);
			wr(8'h01, rows[i][23:16]);
			cyc(2);
			chk("hi", rows[i][15:8], hi);
			chk("lo", rows[i][7:0], lo);
			chk("po", rows[i][15:8], po);
			chk("oe", ~rows[i][31:24], oe);
		end
		wr(8'h00, 8'h00);
		cyc(2);
		chk("rd", 8'h0F, rd);
		por = 0;
		cyc(5);
		chk("oe", 8'h00, oe);
		por = 1;
		cyc(5);
		cka(0);
		ext = 8'h08;
		cyc(5);
		cka(1);
		ext = 8'h00;
		cyc(5);
		cka(0);
		ext = 8'h08;
		cyc(5);
		wr(8'h01, 8'hFF);
		m.read_frame(1);
		cyc(6);
		cka(1);
		chk("ptr", 8'h01, ptr);
		wr(8'h00, 8'h00);
		m.read_frame(1);
		cyc(6);
		cka(0);
		wr(8'h01, 8'hFF);
		ext = 8'h00;
		cyc(5);
		cka(1);
		m.read_frame(0);
		cyc(6);
		cka(0);
		ext = 8'h01;
		cyc(5);
		cka(1);
		m.read_frame(0);
		wr(8'h03, 8'hFE);
		wr(8'h01, 8'hFE);
		cyc(5);
		cka(0);
		ce = 0;
		ext = 8'h03;
		cyc(6);
		cka(0);
		ce = 1;
		cyc(5);
		cka(1);
		chk("an", 8'h00, {7'h00, an});
		end_sim;
	end
endmodule
bind iox_port iox_props u_props (.*);
